// ### otpsp_regs.vh
// Opcodes, field positions, reset values and timing for the OTP/protect core
`ifndef OTPSP_REGS_VH
`define OTPSP_REGS_VH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define OTPSP_OP_WRITE_ENABLE_CMD 8'h06
`define OTPSP_OP_OTP_PROG 8'h42
`define OTPSP_OP_OTP_READ 8'h4b
`define OTPSP_OP_PCFG_READ 8'h2b
`define OTPSP_OP_PCFG_PROG 8'h2f
`define OTPSP_OP_VL_READ 8'hfa
`define OTPSP_OP_VL_READ_W 8'he0
`define OTPSP_OP_VL_WRITE 8'hfb
`define OTPSP_OP_VL_WRITE_W 8'he1
// ----------------------------------------
// Config register two fields
// ----------------------------------------
`define OTPSP_CFG_ADDR32_BIT 7
`define OTPSP_CFG_LAT_MSB 3
`define OTPSP_CFG_LAT_LSB 0
// ----------------------------------------
// Geometry and values
// ----------------------------------------
`define OTPSP_OTP_BYTES 1024
`define OTPSP_OTP_AW 10
`define OTPSP_ECC_SH 4
`define OTPSP_ECC_UNITS 64
`define OTPSP_PCFG_RESET 16'hffff
`define OTPSP_VL_PROTECT 8'h00
`define OTPSP_VL_UNPROTECT 8'hff
`define OTPSP_VL_RESET 8'hff
`define OTPSP_UNDEF_BYTE 8'hff
// ----------------------------------------
// Timing
// ----------------------------------------
`define OTPSP_CLK_NS 10
`define OTPSP_PROG_TIME_NS 2000
`define OTPSP_PROG_CYC ((`OTPSP_PROG_TIME_NS + `OTPSP_CLK_NS - 1) / `OTPSP_CLK_NS)
`endif

// ### otpsp_core.v
// OTP program/read and sector protection command interpreter
// Summary of operation
// - OTP program is accepted only with the write-enable latch set.
// - Programming zeros into a locked OTP region fails and sets error.
// - Programming ones anywhere never errors nor changes the error bit.
// - Programming only clears still-erased bits; ones leave bits alone.
// - A second program of an ECC unit disables ECC for it.
// - OTP program is opcode, address, data; it starts on chip select rise.
// - OTP read is fast read without wrap; beyond the top is undefined.
// - OTP read inserts the configured latency before data.
// - Protect config read sends 16 bits on falling edges, low byte first.
// - Protect config read repeats the same 16 bits while selected.
// - Protect config program starts only if deselected after bit 16.
// - Busy while programming, error unchanged, then config ANDed in and latch cleared.
// - Lock read uses 24/32-bit address per config, wide form always 32.
// - Lock read repeats the one lock byte every eight clocks, every two clocks in quad mode.
// - Quad mode lock read moves all phases over four lines.
// - Lock write starts after byte 8 bits, busy, error, latch cleared.
// - Quad mode lock write moves each byte in two clocks.
`timescale 1ns/1ps
`include "otpsp_regs.vh"
module otpsp_core #(
  parameter BUF_DEPTH = 16,
  parameter BUF_AW = 4,
  parameter SECT_W = 8,
  parameter SECT_SH = 16,
  parameter REGIONS = 16
) (
  // Clock, reset, enable
  input wire ref_clk_i,
  input wire resetn_i,
  input wire ce_i,
  // Serial link pins
  input wire cs_n_i,
  input wire sck_i,
  input wire [3:0] io_i,
  output reg [3:0] io_o,
  output reg [3:0] io_oe_o,
  // Configuration
  input wire quad_command_mode_i,
  input wire [7:0] config_reg_two_i,
  input wire [REGIONS-1:0] otp_region_lock_i,
  // Status
  output reg write_in_progress_o,
  output reg write_enable_latch_o,
  output reg program_error_o,
  output reg [15:0] protect_cfg_o,
  output reg [`OTPSP_ECC_UNITS-1:0] ecc_off_o
);
  localparam PROG_CYC = `OTPSP_PROG_CYC;
  localparam S_CMD = 6'h01;
  localparam S_ADDR = 6'h02;
  localparam S_DUMMY = 6'h04;
  localparam S_DIN = 6'h08;
  localparam S_DOUT = 6'h10;
  localparam S_SKIP = 6'h20;
  localparam RSH = `OTPSP_OTP_AW - $clog2(REGIONS);
  // ----------------------------------------
  // Link synchronisers
  // ----------------------------------------
  reg cs_s1_r, cs_s2_r, cs_s3_r, sck_s1_r, sck_s2_r, sck_s3_r;
  reg [3:0] io_s1_r, io_s2_r;
  always @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_s3_r <= 1'b0;
      io_s1_r <= 4'h0;
      io_s2_r <= 4'h0;
    end
    else if (ce_i)
    begin
      cs_s1_r <= cs_n_i;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      sck_s1_r <= sck_i;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
      io_s1_r <= io_i;
      io_s2_r <= io_s1_r;
    end
  end
  wire sel = ~cs_s2_r;
  wire rise = sel & sck_s2_r & ~sck_s3_r;
  wire fall = sel & ~sck_s2_r & sck_s3_r;
  wire cs_rise = cs_s2_r & ~cs_s3_r;
  // ----------------------------------------
  // Storage and shift state
  // ----------------------------------------
  reg [7:0] otp_mem [0:`OTPSP_OTP_BYTES-1];
  reg [7:0] vl_mem [0:(1<<SECT_W)-1];
  reg [7:0] pbuf [0:BUF_DEPTH-1];
  reg [`OTPSP_ECC_UNITS-1:0] ecc_used_r;
  reg [5:0] state_r, cnt_r, alen_r;
  reg [7:0] op_r, bop_r, nbyte_r;
  reg [31:0] sh_r, addr_r;
  reg [15:0] din_r, bcnt_r;
  reg [3:0] opos_r;
  integer i;
  wire quad = quad_command_mode_i;
  wire [5:0] wd = quad ? 6'h04 : 6'h01;
  wire [5:0] cnt_nxt = cnt_r + wd;
  wire [31:0] sh_nxt = quad ? {sh_r[27:0], io_s2_r} : {sh_r[30:0], io_s2_r[0]};
  wire [5:0] cfg_alen = config_reg_two_i[`OTPSP_CFG_ADDR32_BIT] ?
    6'h20 : 6'h18;
  wire [3:0] lat = config_reg_two_i[`OTPSP_CFG_LAT_MSB:`OTPSP_CFG_LAT_LSB];
  wire [SECT_W-1:0] sect = addr_r[SECT_SH+SECT_W-1:SECT_SH];
  wire [7:0] otp_byte = (|addr_r[31:`OTPSP_OTP_AW]) ? `OTPSP_UNDEF_BYTE :
    otp_mem[addr_r[`OTPSP_OTP_AW-1:0]];
  wire is16 = (op_r == `OTPSP_OP_PCFG_READ);
  wire [15:0] oword = is16 ? protect_cfg_o :
    (op_r == `OTPSP_OP_OTP_READ) ? {8'h00, otp_byte} : {8'h00, vl_mem[sect]};
  wire [7:0] obyte = (is16 & opos_r[3]) ? oword[15:8] : oword[7:0];
  wire [3:0] osum = {1'b0, opos_r[2:0]} + wd[3:0];
  wire is_wr = (op_r == `OTPSP_OP_OTP_PROG) | (op_r == `OTPSP_OP_PCFG_PROG) |
    (op_r == `OTPSP_OP_VL_WRITE) | (op_r == `OTPSP_OP_VL_WRITE_W);
  wire len_ok = (cnt_r == 6'h00) &
    ((op_r == `OTPSP_OP_OTP_PROG) ? (nbyte_r != 8'h00) :
     (op_r == `OTPSP_OP_PCFG_PROG) ? (nbyte_r == 8'h02) : (nbyte_r == 8'h01));
  // Programming walk: one buffered byte per busy cycle
  wire [`OTPSP_OTP_AW-1:0] pa = addr_r[`OTPSP_OTP_AW-1:0] +
    bcnt_r[`OTPSP_OTP_AW-1:0];
  wire [7:0] pd = pbuf[bcnt_r[BUF_AW-1:0]];
  wire p_act = (bop_r == `OTPSP_OP_OTP_PROG) & (bcnt_r < {8'h00, nbyte_r});
  wire p_lock = otp_region_lock_i[pa[`OTPSP_OTP_AW-1:RSH]];
  wire [5:0] p_unit = pa[`OTPSP_OTP_AW-1:`OTPSP_ECC_SH];
  wire done = write_in_progress_o & (bcnt_r == PROG_CYC - 1);
  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_r <= S_CMD;
      op_r <= 8'h00;
      bop_r <= 8'h00;
      cnt_r <= 6'h00;
      alen_r <= 6'h18;
      sh_r <= 32'h0;
      addr_r <= 32'h0;
      din_r <= 16'h0;
      nbyte_r <= 8'h00;
      opos_r <= 4'h0;
      bcnt_r <= 16'h0;
      io_o <= 4'h0;
      io_oe_o <= 4'h0;
      write_in_progress_o <= 1'b0;
      write_enable_latch_o <= 1'b0;
      program_error_o <= 1'b0;
      protect_cfg_o <= `OTPSP_PCFG_RESET;
      ecc_off_o <= {`OTPSP_ECC_UNITS{1'b0}};
      ecc_used_r <= {`OTPSP_ECC_UNITS{1'b0}};
      for (i = 0; i < (1<<SECT_W); i = i + 1)
        vl_mem[i] <= `OTPSP_VL_RESET;
    end
    else if (ce_i)
    begin
      if (!sel)
      begin
        state_r <= S_CMD;
        cnt_r <= 6'h00;
        io_oe_o <= 4'h0;
        opos_r <= 4'h0;
      end
      else if (rise)
      begin
        sh_r <= sh_nxt;
        case (state_r)
          S_CMD:
          begin
            cnt_r <= cnt_nxt;
            if (cnt_nxt == 6'h08)
            begin
              cnt_r <= 6'h00;
              op_r <= sh_nxt[7:0];
              nbyte_r <= 8'h00;
              alen_r <= cfg_alen;
              state_r <= S_SKIP;
              if (!write_in_progress_o)
              begin
                case (sh_nxt[7:0])
                  `OTPSP_OP_WRITE_ENABLE_CMD:
                    write_enable_latch_o <= 1'b1;
                  `OTPSP_OP_OTP_PROG, `OTPSP_OP_VL_WRITE:
                    if (write_enable_latch_o)
                      state_r <= S_ADDR;
                  `OTPSP_OP_OTP_READ, `OTPSP_OP_VL_READ:
                    state_r <= S_ADDR;
                  `OTPSP_OP_VL_READ_W:
                  begin
                    alen_r <= 6'h20;
                    state_r <= S_ADDR;
                  end
                  `OTPSP_OP_VL_WRITE_W:
                  begin
                    alen_r <= 6'h20;
                    if (write_enable_latch_o)
                      state_r <= S_ADDR;
                  end
                  `OTPSP_OP_PCFG_READ:
                    state_r <= S_DOUT;
                  `OTPSP_OP_PCFG_PROG:
                    if (write_enable_latch_o)
                      state_r <= S_DIN;
                  default:
                    state_r <= S_SKIP;
                endcase
              end
            end
          end
          S_ADDR:
          begin
            cnt_r <= cnt_nxt;
            if (cnt_nxt == alen_r)
            begin
              cnt_r <= 6'h00;
              addr_r <= (alen_r == 6'h20) ? sh_nxt : {8'h00, sh_nxt[23:0]};
              if (op_r == `OTPSP_OP_OTP_READ && lat != 4'h0)
                state_r <= S_DUMMY;
              else if (is_wr)
                state_r <= S_DIN;
              else
                state_r <= S_DOUT;
            end
          end
          S_DUMMY:
          begin
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r[3:0] + 4'h1 == lat)
              state_r <= S_DOUT;
          end
          S_DIN:
          begin
            cnt_r <= cnt_nxt;
            if (cnt_nxt == 6'h08)
            begin
              cnt_r <= 6'h00;
              if (nbyte_r != 8'hff)
                nbyte_r <= nbyte_r + 8'h01;
              if (nbyte_r < BUF_DEPTH)
                pbuf[nbyte_r[BUF_AW-1:0]] <= sh_nxt[7:0];
              if (nbyte_r == 8'h00)
                din_r[7:0] <= sh_nxt[7:0];
              else
                din_r[15:8] <= sh_nxt[7:0];
            end
          end
          default:
            state_r <= state_r;
        endcase
      end
      else if (fall && state_r == S_DOUT)
      begin
        if (quad)
        begin
          io_oe_o <= 4'hf;
          io_o <= opos_r[2] ? obyte[3:0] : obyte[7:4];
        end
        else
        begin
          io_oe_o <= 4'h2;
          io_o <= {2'b00, obyte[~opos_r[2:0]], 1'b0};
        end
        opos_r <= is16 ? (opos_r + wd[3:0]) : {1'b0, osum[2:0]};
        if (osum[3] && op_r == `OTPSP_OP_OTP_READ)
          addr_r <= addr_r + 32'h1;
      end
      // Self-timed operation launch and progress
      if (cs_rise && state_r == S_DIN && len_ok && write_enable_latch_o)
      begin
        write_in_progress_o <= 1'b1;
        bop_r <= op_r;
        bcnt_r <= 16'h0;
      end
      else if (write_in_progress_o)
      begin
        bcnt_r <= bcnt_r + 16'h1;
        if (p_act && bcnt_r < BUF_DEPTH)
        begin
          if (p_lock && ~pd != 8'h00)
            program_error_o <= 1'b1;
          else if (!p_lock)
          begin
            otp_mem[pa] <= otp_mem[pa] & pd;
            ecc_used_r[p_unit] <= 1'b1;
            if (ecc_used_r[p_unit])
              ecc_off_o[p_unit] <= 1'b1;
          end
        end
        if (done)
        begin
          write_in_progress_o <= 1'b0;
          write_enable_latch_o <= 1'b0;
          if (bop_r == `OTPSP_OP_PCFG_PROG)
            protect_cfg_o <= protect_cfg_o & din_r;
          else if (bop_r != `OTPSP_OP_OTP_PROG)
          begin
            if (din_r[7:0] == `OTPSP_VL_PROTECT ||
                din_r[7:0] == `OTPSP_VL_UNPROTECT)
              vl_mem[sect] <= din_r[7:0];
            else
              program_error_o <= 1'b1;
          end
        end
      end
    end
  end
endmodule // otpsp_core

// ### otpsp_chk.sv
// Assertion checker for the OTP and sector protect core
`timescale 1ns/1ps
`include "otpsp_regs.vh"
module otpsp_chk (
  // Clock and reset
  input wire ref_clk_i,
  input wire resetn_i,
  // Pins and status
  input wire cs_n_i,
  input wire quad_command_mode_i,
  input wire [3:0] io_oe_o,
  input wire write_in_progress_o,
  input wire write_enable_latch_o,
  input wire program_error_o,
  input wire [15:0] protect_cfg_o,
  input wire [`OTPSP_ECC_UNITS-1:0] ecc_off_o
);
  wire write_in_progress = write_in_progress_o;
  wire write_enable_latch = write_enable_latch_o;
  wire perr = program_error_o;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  a_oe_shape: assert property (
    io_oe_o == 4'h0 || io_oe_o == (quad_command_mode_i ? 4'hf : 4'h2))
    else $error("output enable pattern wrong");
  a_oe_idle: assert property (
    cs_n_i [*6] |-> io_oe_o == 4'h0)
    else $error("driving while deselected");
  a_start_cond: assert property (
    $rose(write_in_progress) |-> cs_n_i && $past(write_enable_latch))
    else $error("busy without latch or deselect");
  a_busy_len: assert property (
    $rose(write_in_progress) |-> ##150 write_in_progress ##[1:60] !write_in_progress)
    else $error("busy length wrong");
  a_done_wel: assert property (
    $fell(write_in_progress) |-> !write_enable_latch)
    else $error("latch still set after busy");
  a_perr_stay: assert property (
    perr |=> perr)
    else $error("error bit dropped");
  a_perr_cause: assert property (
    $rose(perr) |-> write_in_progress || $past(write_in_progress))
    else $error("error bit outside programming");
  a_ecc_stay: assert property (
    (ecc_off_o & $past(ecc_off_o)) == $past(ecc_off_o))
    else $error("ecc off flag cleared");
  a_cfg_and: assert property (
    (protect_cfg_o & ~$past(protect_cfg_o)) == 16'h0)
    else $error("protect config gained ones");
  a_cfg_quiet: assert property (
    (!write_in_progress) [*4] |-> $stable(protect_cfg_o))
    else $error("protect config changed while idle");
endmodule // otpsp_chk
bind otpsp_core otpsp_chk u_chk (.ref_clk_i, .resetn_i, .cs_n_i,
  .quad_command_mode_i, .io_oe_o, .write_in_progress_o,
  .write_enable_latch_o, .program_error_o, .protect_cfg_o, .ecc_off_o);

// ### otpsp_host.sv
// Host serial controller model for the OTP and sector protect core
`timescale 1ns/1ps
module otpsp_host (
  // Clock and mode
  input wire ref_clk_i,
  input wire quad_i,
  // Link pins
  input wire [3:0] pin_i,
  output reg cs_n_o,
  output reg sck_o,
  output reg [3:0] io_o
);
  reg [7:0] tx [0:7];
  reg [7:0] rx [0:7];
  // Clock stands low outside frames
  initial
  begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    io_o = 4'h5;
  end
  // whole bytes, deselect after last bit
  task frame(input integer n);
    integer i;
    integer j;
    begin
      @(negedge ref_clk_i);
      cs_n_o = 1'b0;
      repeat (4) @(negedge ref_clk_i);
      for (i = 0; i < n; i = i + 1)
      begin
        for (j = 0; j < (quad_i ? 2 : 8); j = j + 1)
        begin
          // high nibble first, unused lines toggle
          if (quad_i)
            io_o = j ? tx[i][3:0] : tx[i][7:4];
          else
            io_o = {~io_o[3:1], tx[i][7 - j]};
          repeat (8) @(negedge ref_clk_i);
          if (quad_i)
            rx[i] = {rx[i][3:0], pin_i};
          else
            rx[i] = {rx[i][6:0], pin_i[1]};
          sck_o = 1'b1;
          repeat (8) @(negedge ref_clk_i);
          sck_o = 1'b0;
        end
      end
      repeat (4) @(negedge ref_clk_i);
      cs_n_o = 1'b1;
      io_o = ~io_o;
      repeat (8) @(negedge ref_clk_i);
    end
  endtask
endmodule // otpsp_host

// ### test_otp_and_sector_protect_commands.sv
// Self-checking bench for the OTP and sector protect core
`timescale 1ns/1ps
`include "otpsp_regs.vh"
module test_otp_and_sector_protect_commands;
  reg ref_clk_i = 1'b0;
  reg resetn_i = 1'b0;
  reg quad_command_mode_i = 1'b0;
  reg [7:0] config_reg_two_i = 8'h08;
  reg ce_i = 1'b1;
  integer k;
  integer error_cnt = 0;
  integer total_checks = 0;
  wire cs_n;
  wire sck;
  wire [3:0] hio;
  wire [3:0] dio;
  wire [3:0] doe;
  wire write_in_progress;
  wire write_enable_latch;
  wire perr;
  wire [15:0] pcfg;
  wire [63:0] ecc;
  // Released lines show the host's changing pattern
  wire [3:0] io_w = (dio & doe) | (hio & ~doe);
  always #5 ref_clk_i = ~ref_clk_i;
  otpsp_core uut (.ref_clk_i, .resetn_i, .ce_i, .cs_n_i(cs_n),
    .sck_i(sck), .io_i(io_w), .io_o(dio), .io_oe_o(doe),
    .quad_command_mode_i, .config_reg_two_i,
    .otp_region_lock_i(16'h0002), .write_in_progress_o(write_in_progress),
    .write_enable_latch_o(write_enable_latch), .program_error_o(perr),
    .protect_cfg_o(pcfg), .ecc_off_o(ecc));
  otpsp_host host (.ref_clk_i, .quad_i(quad_command_mode_i),
    .pin_i(io_w), .cs_n_o(cs_n), .sck_o(sck), .io_o(hio));
  task chk(input [63:0] got, input [63:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task cmd(input [63:0] v, input integer n);
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1)
        host.tx[i] = v[63 - 8 * i -: 8];
      host.frame(n);
    end
  endtask
  task prog(input [63:0] v, input integer n);
    integer i;
    begin
      cmd({`OTPSP_OP_WRITE_ENABLE_CMD, 56'h0}, 1);
      chk(write_enable_latch, 1'b1);
      cmd(v, n);
      chk(write_in_progress, 1'b1);
      for (i = 0; i < 400 && write_in_progress !== 1'b0; i = i + 1)
        @(negedge ref_clk_i);
      chk({write_in_progress, write_enable_latch}, 2'b00);
    end
  endtask
  task t_pcfg;
    begin
      chk({write_in_progress, write_enable_latch, perr, doe}, 7'h00);
      chk(ecc, 64'h0);
      ce_i = 1'b0;
      cmd({`OTPSP_OP_WRITE_ENABLE_CMD, 56'h0}, 1);
      ce_i = 1'b1;
      chk(write_enable_latch, 1'b0);
      chk(pcfg, `OTPSP_PCFG_RESET);
      cmd({`OTPSP_OP_PCFG_PROG, 16'h3412, 40'h0}, 3);
      chk({write_in_progress, pcfg}, {1'b0, 16'hffff});
      prog({`OTPSP_OP_PCFG_PROG, 16'h3412, 40'h0}, 3);
      chk(pcfg, 16'h1234);
      cmd({`OTPSP_OP_WRITE_ENABLE_CMD, 56'h0}, 1);
      cmd({`OTPSP_OP_PCFG_PROG, 16'h00, 40'h0}, 2);
      chk({write_in_progress, pcfg}, {1'b0, 16'h1234});
      cmd({`OTPSP_OP_PCFG_READ, 56'h0}, 5);
      chk({host.rx[1], host.rx[2], host.rx[3], host.rx[4]},
        32'h34123412);
      $display("protect config test done");
    end
  endtask
  task t_lock;
    begin
      prog({`OTPSP_OP_VL_WRITE, 24'h050000, 8'h00, 24'h0}, 5);
      cmd({`OTPSP_OP_VL_READ, 24'h050000, 32'h0}, 6);
      chk({host.rx[4], host.rx[5]}, 16'h0000);
      cmd({`OTPSP_OP_VL_READ, 24'h060000, 32'h0}, 5);
      chk(host.rx[4], `OTPSP_VL_RESET);
      config_reg_two_i = 8'h80;
      cmd({`OTPSP_OP_VL_READ, 32'h00050000, 24'h0}, 6);
      chk(host.rx[5], 8'h00);
      config_reg_two_i = 8'h08;
      cmd({`OTPSP_OP_VL_READ_W, 32'h00050000, 24'h0}, 6);
      chk(host.rx[5], 8'h00);
      quad_command_mode_i = 1'b1;
      prog({`OTPSP_OP_VL_WRITE_W, 32'h00070000, 8'h00, 16'h0}, 6);
      cmd({`OTPSP_OP_VL_READ, 24'h070000, 32'h0}, 6);
      chk({host.rx[4], host.rx[5]}, 16'h0000);
      prog({`OTPSP_OP_VL_WRITE, 24'h070000, 8'hff, 24'h0}, 5);
      cmd({`OTPSP_OP_VL_READ, 24'h070000, 32'h0}, 5);
      chk(host.rx[4], 8'hff);
      quad_command_mode_i = 1'b0;
      $display("volatile lock test done");
    end
  endtask
  task t_otp;
    begin
      prog({`OTPSP_OP_OTP_PROG, 24'h000010, 8'ha5, 24'h0}, 5);
      chk(ecc[1], 1'b0);
      cmd({`OTPSP_OP_OTP_READ, 24'h000010, 32'h0}, 6);
      chk(host.rx[5], 8'ha5);
      prog({`OTPSP_OP_OTP_PROG, 24'h000010, 8'hf0, 24'h0}, 5);
      cmd({`OTPSP_OP_OTP_READ, 24'h000010, 32'h0}, 6);
      chk({host.rx[5], ecc[1]}, {8'ha0, 1'b1});
      prog({`OTPSP_OP_OTP_PROG, 24'h000040, 8'hff, 24'h0}, 5);
      chk(perr, 1'b0);
      prog({`OTPSP_OP_OTP_PROG, 24'h000040, 8'h00, 24'h0}, 5);
      chk(perr, 1'b1);
      prog({`OTPSP_OP_OTP_PROG, 24'h000000, 8'h3c, 24'h0}, 5);
      cmd({`OTPSP_OP_OTP_READ, 24'h0003ff, 32'h0}, 7);
      chk({host.rx[5], host.rx[6]}, {8'hff, `OTPSP_UNDEF_BYTE});
      $display("one time area test done");
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial
  begin
    // Erased OTP content, never reset by the core
    for (k = 0; k < `OTPSP_OTP_BYTES; k = k + 1)
      uut.otp_mem[k] = 8'hff;
    repeat (8) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    t_pcfg;
    t_lock;
    t_otp;
    stop_test;
  end
  // Run needs about 15k cycles
  initial
  begin
    #900000;
    error_cnt = error_cnt + 1;
    stop_test;
  end
endmodule // test_otp_and_sector_protect_commands
